// [rtl/dsf_decoder.sv]
// Serial special-function decoder: select, monitor, pin and readback
//
// Function
// - Block select write loads every select bit of both registers with data.
// - Monitor command: F5 high enables monitor output, low disables it.
// - Monitor command with F4 high routes a monitor pin, chosen by F0.
// - Monitor command with F4 low routes DAC channel F3:F0 to monitor.
// - With pin source chosen, bits F3 to F1 are ignored.
// - F4 and F5 high: F0 low picks pin 0, high picks pin 1.
// - Pin command with F1 high makes pin an output driving F0.
// - Pin command with F1 low makes pin an input; readback shows level.
// - Readback select ignores data bits F6 to F0.
// - Readback code 100001011 returns the pin state in bit F0.
// - Codes 100000110/111 return select registers; other unnamed codes with F15 high are reserved.
// - A zero select bit makes its channel use the data-A register.
// - A one picks data-B; register 0 serves DAC 3..0, register 1 DAC 7..4.
// - Single select write loads F3..F0 into the addressed select register.
// - Readback-select function carries the readback address code in its data.
`timescale 1ns/1ps
`default_nettype none

module dsf_decoder #(
	parameter int unsigned CHANNELS = 8,
	parameter int unsigned DATA_W   = 16
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic                sclk,
	input  wire logic                sync_n,
	input  wire logic                sdi,
	input  wire logic                gpio_i,
	input  wire logic [DATA_W-1:0]   ctrl_rdata,
	input  wire logic [DATA_W-1:0]   group0_offset_level_rdata,
	input  wire logic [DATA_W-1:0]   group1_offset_level_rdata,
	input  wire logic [DATA_W-1:0]   chan_rdata,
	output var  logic                sdo,
	output var  logic [CHANNELS-1:0] chan_use_b,
	output var  logic                mon_enable,
	output var  logic                mon_from_pin,
	output var  logic                mon_pin_sel,
	output var  logic [3:0]          mon_chan,
	output var  logic                gpio_o,
	output var  logic                gpio_oe,
	output var  logic [3:0]          rb_src,
	output var  logic [5:0]          rb_chan_addr,
	output var  logic [23:0]         cmd_word,
	output var  logic                cmd_strobe
);

	// ==========================================================
	// Pin synchronisation and edge detection
	logic [3:0] pins_s;
	logic       sclk_s;
	logic       sync_n_s;
	logic       sdi_s;
	logic       gpio_s;
	logic       sclk_d_ff;
	logic       sync_n_d_ff;

	dsf_sync #(
		.W       (4),
		.RST_VAL (dsf_pkg::PIN_SYNC_RST)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({gpio_i, sdi, sync_n, sclk}),
		.q    (pins_s)
	);

	assign sclk_s   = pins_s[0];
	assign sync_n_s = pins_s[1];
	assign sdi_s    = pins_s[2];
	assign gpio_s   = pins_s[3];

	// Delayed copies for edge detection, read from synchronised stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			sclk_d_ff   <= 1'b0;
			sync_n_d_ff <= 1'b1;
		end else begin
			sclk_d_ff   <= sclk_s;
			sync_n_d_ff <= sync_n_s;
		end
	end

	logic sclk_fall;
	logic sync_fall;
	logic sync_rise;
	logic shift_en;

	assign sclk_fall = sclk_d_ff & ~sclk_s;
	assign sync_fall = sync_n_d_ff & ~sync_n_s;
	assign sync_rise = ~sync_n_d_ff & sync_n_s;
	assign shift_en  = sclk_fall & ~sync_n_s;

	// ==========================================================
	// Receive shift register and bit counter
	logic [23:0]              rx_ff;
	logic [dsf_pkg::CNT_W-1:0] cnt_ff;
	logic [dsf_pkg::CNT_W-1:0] nxt_cnt;

	// Counter saturates so an overlong frame never aliases to 24
	assign nxt_cnt = sync_fall ? '0 :
		(shift_en && cnt_ff != dsf_pkg::CNT_MAX) ? cnt_ff + 1'b1 : cnt_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			rx_ff  <= shift_en ? {rx_ff[22:0], sdi_s} : rx_ff;
			cnt_ff <= nxt_cnt;
		end
	end

	// ==========================================================
	// Frame decode, acted on when the frame closes
	logic        frame_ok;
	logic        special;
	logic [5:0]  func;
	logic [15:0] fdata;
	logic        wr_sel0;
	logic        wr_sel1;
	logic        wr_block;
	logic        wr_mon;
	logic        wr_gpio;
	logic        wr_rbsel;

	assign frame_ok = sync_rise & (cnt_ff == dsf_pkg::FRAME_COUNT);
	assign special  = frame_ok & (rx_ff[dsf_pkg::MODE_HI:dsf_pkg::MODE_LO] == dsf_pkg::MODE_SPECIAL);
	assign func     = rx_ff[dsf_pkg::FUNC_HI:dsf_pkg::FUNC_LO];
	assign fdata    = rx_ff[15:0];
	assign wr_sel0  = special & (func == dsf_pkg::FN_SEL0);
	assign wr_sel1  = special & (func == dsf_pkg::FN_SEL1);
	assign wr_block = special & (func == dsf_pkg::FN_SEL_BLOCK);
	assign wr_mon   = special & (func == dsf_pkg::FN_MONITOR);
	assign wr_gpio  = special & (func == dsf_pkg::FN_GPIO);
	assign wr_rbsel = special & (func == dsf_pkg::FN_RB_SELECT);

	// ==========================================================
	// Source select registers
	logic [7:0] sel0_ff;
	logic [7:0] sel1_ff;
	logic [7:0] nxt_sel0;
	logic [7:0] nxt_sel1;

	// Single writes keep the reserved upper bits as they were
	assign nxt_sel0 = wr_block ? fdata[7:0] :
		wr_sel0 ? {sel0_ff[7:4], fdata[3:0]} : sel0_ff;
	assign nxt_sel1 = wr_block ? fdata[7:0] :
		wr_sel1 ? {sel1_ff[7:4], fdata[3:0]} : sel1_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sel0_ff <= dsf_pkg::SEL_RST;
			sel1_ff <= dsf_pkg::SEL_RST;
		end else begin
			sel0_ff <= nxt_sel0;
			sel1_ff <= nxt_sel1;
		end
	end

	// Per-channel A/B choice: low half from register 0, upper from 1
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
			if (gi < 4) begin : g_lo
				assign chan_use_b[gi] = sel0_ff[gi];
			end else begin : g_hi
				assign chan_use_b[gi] = sel1_ff[gi - 4];
			end
		end
	endgenerate

	// ==========================================================
	// Monitor multiplexer control
	logic       mon_en_ff;
	logic       mon_pin_ff;
	logic       mon_psel_ff;
	logic [3:0] mon_chan_ff;
	logic       use_pin;

	assign use_pin = fdata[dsf_pkg::MON_PIN_BIT];

	// Channel field held while a pin source is chosen
	always_ff @(posedge mclk) begin
		if (rst) begin
			mon_en_ff   <= 1'b0;
			mon_pin_ff  <= 1'b0;
			mon_psel_ff <= 1'b0;
			mon_chan_ff <= dsf_pkg::MON_CHAN_RST;
		end else if (wr_mon) begin
			mon_en_ff   <= fdata[dsf_pkg::MON_EN_BIT];
			mon_pin_ff  <= use_pin;
			mon_psel_ff <= use_pin ? fdata[0] : mon_psel_ff;
			mon_chan_ff <= use_pin ? mon_chan_ff : fdata[3:0];
		end
	end

	assign mon_enable   = mon_en_ff;
	assign mon_from_pin = mon_pin_ff;
	assign mon_pin_sel  = mon_psel_ff;
	assign mon_chan     = mon_chan_ff;

	// ==========================================================
	// General-purpose pin
	logic gpio_oe_ff;
	logic gpio_out_ff;
	logic gpio_level;

	always_ff @(posedge mclk) begin
		if (rst) begin
			gpio_oe_ff  <= 1'b0;
			gpio_out_ff <= 1'b0;
		end else if (wr_gpio) begin
			gpio_oe_ff  <= fdata[dsf_pkg::GPIO_DIR_BIT];
			gpio_out_ff <= fdata[dsf_pkg::GPIO_VAL_BIT] & fdata[dsf_pkg::GPIO_DIR_BIT];
		end
	end

	assign gpio_o  = gpio_out_ff;
	assign gpio_oe = gpio_oe_ff;
	// Output mode reads back the driven value, input mode the pin
	assign gpio_level = gpio_oe_ff ? gpio_out_ff : gpio_s;

	// ==========================================================
	// Readback address decode; F6..F0 never looked at
	logic [8:0]             rb_code;
	logic [2:0]             rb_pfx;
	dsf_pkg::dsf_rb_type    rb_dec;
	dsf_pkg::dsf_rb_type    rb_src_ff;
	logic [5:0]             rb_chan_ff;

	assign rb_code = fdata[dsf_pkg::RB_CODE_HI:dsf_pkg::RB_CODE_LO];
	assign rb_pfx  = fdata[dsf_pkg::RB_CODE_HI:dsf_pkg::RB_PFX_LO];
	assign rb_dec  =
		(rb_pfx == dsf_pkg::RB_PFX_DATA_A) ? dsf_pkg::RB_DATA_A :
		(rb_pfx == dsf_pkg::RB_PFX_DATA_B) ? dsf_pkg::RB_DATA_B :
		(rb_pfx == dsf_pkg::RB_PFX_OFSTRM) ? dsf_pkg::RB_OFSTRM :
		(rb_pfx == dsf_pkg::RB_PFX_GAIN)   ? dsf_pkg::RB_GAIN   :
		(rb_code == dsf_pkg::RB_CODE_CTRL) ? dsf_pkg::RB_CTRL   :
		(rb_code == dsf_pkg::RB_CODE_GROUP0_OFFSET_LEVEL) ? dsf_pkg::RB_GROUP0_OFFSET_LEVEL   :
		(rb_code == dsf_pkg::RB_CODE_GROUP1_OFFSET_LEVEL) ? dsf_pkg::RB_GROUP1_OFFSET_LEVEL   :
		(rb_code == dsf_pkg::RB_CODE_SEL0) ? dsf_pkg::RB_SEL0   :
		(rb_code == dsf_pkg::RB_CODE_SEL1) ? dsf_pkg::RB_SEL1   :
		(rb_code == dsf_pkg::RB_CODE_GPIO) ? dsf_pkg::RB_GPIO   :
		dsf_pkg::RB_RSVD;

	// Source armed until the next frame opens, then dropped; channel address kept
	always_ff @(posedge mclk) begin
		if (rst) begin
			rb_src_ff  <= dsf_pkg::RB_NONE;
			rb_chan_ff <= '0;
		end else if (wr_rbsel) begin
			rb_src_ff  <= rb_dec;
			rb_chan_ff <= fdata[dsf_pkg::RB_CHAN_HI:dsf_pkg::RB_CODE_LO];
		end else if (sync_fall) begin
			rb_src_ff  <= dsf_pkg::RB_NONE;
		end
	end

	assign rb_src       = rb_src_ff;
	assign rb_chan_addr = rb_chan_ff;

	// ==========================================================
	// Readback word and transmit shift register
	logic [15:0] rb_data;
	logic [23:0] tx_ff;
	logic [23:0] nxt_tx;

	// Reserved codes and idle frames shift out zeros
	assign rb_data =
		(rb_src_ff == dsf_pkg::RB_DATA_A || rb_src_ff == dsf_pkg::RB_DATA_B ||
		 rb_src_ff == dsf_pkg::RB_OFSTRM || rb_src_ff == dsf_pkg::RB_GAIN) ? chan_rdata :
		(rb_src_ff == dsf_pkg::RB_CTRL) ? ctrl_rdata :
		(rb_src_ff == dsf_pkg::RB_GROUP0_OFFSET_LEVEL) ? group0_offset_level_rdata :
		(rb_src_ff == dsf_pkg::RB_GROUP1_OFFSET_LEVEL) ? group1_offset_level_rdata :
		(rb_src_ff == dsf_pkg::RB_SEL0) ? {8'h00, sel0_ff} :
		(rb_src_ff == dsf_pkg::RB_SEL1) ? {8'h00, sel1_ff} :
		(rb_src_ff == dsf_pkg::RB_GPIO) ? {15'h0000, gpio_level} :
		16'h0000;

	// Word loaded as the frame opens, MSB first, advanced per falling edge
	assign nxt_tx = sync_fall ? {8'h00, rb_data} :
		shift_en ? {tx_ff[22:0], 1'b0} : tx_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_ff <= '0;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	assign sdo = tx_ff[23];

	// ==========================================================
	// Every complete frame is offered to the rest of the device
	logic [23:0] cmd_word_ff;
	logic        cmd_strobe_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_word_ff   <= '0;
			cmd_strobe_ff <= 1'b0;
		end else begin
			cmd_word_ff   <= frame_ok ? rx_ff : cmd_word_ff;
			cmd_strobe_ff <= frame_ok;
		end
	end

	assign cmd_word   = cmd_word_ff;
	assign cmd_strobe = cmd_strobe_ff;

endmodule

`default_nettype wire

// [rtl/dsf_pkg.sv]
// Constants and types shared by the special-function decoder
package dsf_pkg;

	// ==========================================================
	// Serial frame layout
	localparam int unsigned FRAME_BITS  = 24;
	localparam int unsigned CNT_W       = 5;
	localparam logic [4:0]  FRAME_COUNT = 5'h18;
	localparam logic [4:0]  CNT_MAX     = 5'h1f;
	localparam int unsigned MODE_HI     = 23;
	localparam int unsigned MODE_LO     = 22;
	localparam int unsigned FUNC_HI     = 21;
	localparam int unsigned FUNC_LO     = 16;
	localparam logic [1:0]  MODE_SPECIAL = 2'h0;

	// ==========================================================
	// Special-function codes handled here
	localparam logic [5:0] FN_NOP       = 6'h00;
	localparam logic [5:0] FN_RB_SELECT = 6'h05;
	localparam logic [5:0] FN_SEL0      = 6'h06;
	localparam logic [5:0] FN_SEL1      = 6'h07;
	localparam logic [5:0] FN_SEL_BLOCK = 6'h0b;
	localparam logic [5:0] FN_MONITOR   = 6'h0c;
	localparam logic [5:0] FN_GPIO      = 6'h0d;

	// ==========================================================
	// Data field positions
	localparam int unsigned MON_EN_BIT   = 5;
	localparam int unsigned MON_PIN_BIT  = 4;
	localparam int unsigned GPIO_DIR_BIT = 1;
	localparam int unsigned GPIO_VAL_BIT = 0;
	localparam int unsigned RB_CODE_HI   = 15;
	localparam int unsigned RB_CODE_LO   = 7;
	localparam int unsigned RB_PFX_LO    = 13;
	localparam int unsigned RB_CHAN_HI   = 12;

	// ==========================================================
	// Readback address codes, F15..F7
	localparam logic [2:0] RB_PFX_DATA_A = 3'h0;
	localparam logic [2:0] RB_PFX_DATA_B = 3'h1;
	localparam logic [2:0] RB_PFX_OFSTRM = 3'h2;
	localparam logic [2:0] RB_PFX_GAIN   = 3'h3;
	localparam logic [8:0] RB_CODE_CTRL  = 9'h101;
	localparam logic [8:0] RB_CODE_GROUP0_OFFSET_LEVEL  = 9'h102;
	localparam logic [8:0] RB_CODE_GROUP1_OFFSET_LEVEL  = 9'h103;
	localparam logic [8:0] RB_CODE_SEL0  = 9'h106;
	localparam logic [8:0] RB_CODE_SEL1  = 9'h107;
	localparam logic [8:0] RB_CODE_GPIO  = 9'h10b;

	// ==========================================================
	// Reset values
	localparam logic [7:0] SEL_RST      = 8'h00;
	localparam logic [3:0] MON_CHAN_RST = 4'h0;
	localparam logic [3:0] PIN_SYNC_RST = 4'h6;

	// Source of the word shifted out on the next frame
	typedef enum logic [3:0] {
		RB_NONE   = 4'b0000,
		RB_DATA_A = 4'b0001,
		RB_DATA_B = 4'b0010,
		RB_OFSTRM = 4'b0011,
		RB_GAIN   = 4'b0100,
		RB_CTRL   = 4'b0101,
		RB_GROUP0_OFFSET_LEVEL   = 4'b0110,
		RB_GROUP1_OFFSET_LEVEL   = 4'b0111,
		RB_SEL0   = 4'b1000,
		RB_SEL1   = 4'b1001,
		RB_GPIO   = 4'b1010,
		RB_RSVD   = 4'b1011
	} dsf_rb_type;

endpackage

// [rtl/dsf_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dsf_sync #(
	parameter int unsigned  W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_ff;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_ff <= RST_VAL;
			q       <= RST_VAL;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule

`default_nettype wire

// [sim/dsf_decoder_monitor.sv]
// Concurrent checks on the special-function decoder ports
`timescale 1ns/1ps
`default_nettype none

module dsf_decoder_monitor (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  chan_use_b,
	input wire logic        mon_enable,
	input wire logic        mon_from_pin,
	input wire logic        mon_pin_sel,
	input wire logic [3:0]  mon_chan,
	input wire logic        gpio_o,
	input wire logic        gpio_oe,
	input wire logic [3:0]  rb_src,
	input wire logic [23:0] cmd_word,
	input wire logic        cmd_strobe
);
	// ==========================================================
	// Frame effects are already visible in the strobe cycle
	wire [7:0] op = cmd_word[23:16];
	wire [8:0] code = cmd_word[15:7];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	block_sel_a: assert property (cmd_strobe && op == 8'h0b |-> chan_use_b == {2{cmd_word[3:0]}})
		else $error("block select wrong");
	single_sel_a: assert property (cmd_strobe && op == 8'h06 |-> chan_use_b[3:0] == cmd_word[3:0]
		&& chan_use_b[7:4] == $past(chan_use_b[7:4])) else $error("single select wrong");
	mon_en_a: assert property (cmd_strobe && op == 8'h0c |-> mon_enable == cmd_word[5])
		else $error("monitor enable wrong");
	mon_pin_a: assert property (cmd_strobe && op == 8'h0c && cmd_word[4] |-> mon_from_pin
		&& mon_pin_sel == cmd_word[0] && mon_chan == $past(mon_chan)) else $error("monitor pin wrong");
	mon_chan_a: assert property (cmd_strobe && op == 8'h0c && !cmd_word[4] |-> !mon_from_pin
		&& mon_chan == cmd_word[3:0]) else $error("monitor channel wrong");
	pin_out_a: assert property (cmd_strobe && op == 8'h0d && cmd_word[1] |-> gpio_oe && gpio_o == cmd_word[0])
		else $error("pin drive wrong");
	pin_in_a: assert property (cmd_strobe && op == 8'h0d && !cmd_word[1] |-> !gpio_oe)
		else $error("pin not released");
	rb_sel_a: assert property (cmd_strobe && op == 8'h05 && code[8:1] == 8'h83
		|-> rb_src == (code[0] ? dsf_pkg::RB_SEL1 : dsf_pkg::RB_SEL0)) else $error("select readback wrong");
	rb_pin_a: assert property (cmd_strobe && op == 8'h05 && code == 9'h10b |-> rb_src == dsf_pkg::RB_GPIO)
		else $error("pin readback wrong");
	strobe_one_a: assert property (cmd_strobe |=> !cmd_strobe ##1 $stable(chan_use_b))
		else $error("strobe too long");
endmodule

bind dsf_decoder dsf_decoder_monitor MON (.mclk, .rst, .chan_use_b, .mon_enable, .mon_from_pin, .mon_pin_sel,
	.mon_chan, .gpio_o, .gpio_oe, .rb_src, .cmd_word, .cmd_strobe);

`default_nettype wire

// [sim/dsf_decoder_tb.sv]
// Self-checking bench for the special-function decoder
`timescale 1ns/1ps
`default_nettype none

module dsf_decoder_tb;
	logic        mclk, rst, sclk, sync_n, sdi, sdo, gpio_i, gpio_o, gpio_oe, cmd_strobe;
	logic        mon_enable, mon_from_pin, mon_pin_sel, mfp, mps, gp_drv, gp_val;
	logic [15:0] ctrl_rdata, group0_offset_level_rdata, group1_offset_level_rdata, chan_rdata, rnd;
	logic [7:0]  chan_use_b, sel0, sel1, v;
	logic [3:0]  mon_chan, rb_src, mch;
	logic [5:0]  rb_chan_addr;
	logic [23:0] cmd_word, got;
	logic [8:0]  codes [7];
	int          bad_count, checked;

	// ==========================================================
	// Design, host and clock
	dsf_decoder DUT (.mclk, .rst, .sclk, .sync_n, .sdi, .gpio_i, .ctrl_rdata, .group0_offset_level_rdata, .group1_offset_level_rdata,
		.chan_rdata, .sdo, .chan_use_b, .mon_enable, .mon_from_pin, .mon_pin_sel, .mon_chan, .gpio_o,
		.gpio_oe, .rb_src, .rb_chan_addr, .cmd_word, .cmd_strobe);
	dsf_host host (.sclk, .sync_n, .sdi, .sdo);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Word the host should see after a readback select
	function automatic logic [15:0] rb_exp(input logic [8:0] c);
		if (!c[8]) return chan_rdata;
		case (c)
			9'h101: return ctrl_rdata;
			9'h102: return group0_offset_level_rdata;
			9'h103: return group1_offset_level_rdata;
			9'h106: return {8'h00, sel0};
			9'h107: return {8'h00, sel1};
			9'h10b: return {15'h0000, gp_drv ? gp_val : gpio_i};
			default: return 16'h0000;
		endcase
	endfunction
	// Readback source that a select frame should arm
	function automatic logic [3:0] src_exp(input logic [8:0] c);
		case (c[8:6])
			3'h0: return dsf_pkg::RB_DATA_A;
			3'h1: return dsf_pkg::RB_DATA_B;
			3'h2: return dsf_pkg::RB_OFSTRM;
			3'h3: return dsf_pkg::RB_GAIN;
			default: ;
		endcase
		case (c)
			9'h101: return dsf_pkg::RB_CTRL;
			9'h102: return dsf_pkg::RB_GROUP0_OFFSET_LEVEL;
			9'h103: return dsf_pkg::RB_GROUP1_OFFSET_LEVEL;
			9'h106: return dsf_pkg::RB_SEL0;
			9'h107: return dsf_pkg::RB_SEL1;
			9'h10b: return dsf_pkg::RB_GPIO;
			default: return dsf_pkg::RB_RSVD;
		endcase
	endfunction

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [23:0] w);
		host.frame(24, w, got);
		chk(cmd_word, w);
	endtask
	// Select then shift out with a no-op frame
	task automatic rb(input logic [8:0] c, input logic [6:0] low);
		send({8'h05, c, low});
		chk(rb_src, src_exp(c));
		chk(rb_chan_addr, c[5:0]);
		send(24'h00_0000);
		chk(got, {8'h00, rb_exp(c)});
		chk(rb_src, 4'h0);
	endtask
	// Fresh random values on the register contents and the pin
	task automatic step();
		@(posedge mclk);
		rnd = lfsr(rnd);
		ctrl_rdata <= rnd;
		group0_offset_level_rdata <= ~rnd;
		group1_offset_level_rdata <= {rnd[7:0], rnd[15:8]};
		chan_rdata <= rnd ^ 16'ha55a;
		gpio_i <= rnd[3];
		repeat (4) @(posedge mclk);
	endtask
	// Ten cycles of reset, then every output except cmd_word must be back at zero
	task automatic reset_pulse();
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({sdo, cmd_strobe, gpio_oe, gpio_o, rb_src, chan_use_b}, 24'h00_0000);
		chk({mon_enable, mon_from_pin, mon_pin_sel, mon_chan, rb_chan_addr}, 24'h00_0000);
	endtask
	task automatic results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog at twice the roughly 300 us of traffic, about 60k cycles
	initial begin
		#600000;
		bad_count++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{gpio_i, ctrl_rdata, group0_offset_level_rdata, group1_offset_level_rdata, chan_rdata} = 65'h0;
		{sel0, sel1, gp_drv, gp_val, mfp, mps, mch} = '0;
		rnd = 16'h7cf6;
		codes = '{9'h101, 9'h102, 9'h103, 9'h104, 9'h108, 9'h109, 9'h10a};
		reset_pulse();
		for (int i = 0; i < 6; i++) begin
			step();
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
			send({8'h0b, rnd[15:8], v});
			{sel0, sel1} = {v, v};
			chk(chan_use_b, {v[3:0], v[3:0]});
			rb(9'h106, rnd[6:0]);
			rb(9'h107, rnd[14:8]);
		end
		for (int i = 0; i < 4; i++) begin
			step();
			send({7'h03, i[0], rnd});
			if (i[0]) sel1[3:0] = rnd[3:0];
			else sel0[3:0] = rnd[3:0];
			chk(chan_use_b, {sel1[3:0], sel0[3:0]});
			rb({8'h83, i[0]}, 7'h00);
		end
		for (int i = 0; i < 8; i++) begin
			step();
			send({8'h0c, rnd[15:5], i[0], rnd[3:0]});
			if (i[0]) {mfp, mps} = {1'b1, rnd[0]};
			else {mfp, mch} = {1'b0, rnd[3:0]};
			chk({mon_enable, mon_from_pin, mon_pin_sel, mon_chan}, {rnd[5], mfp, mps, mch});
		end
		for (int i = 0; i < 4; i++) begin
			step();
			{gp_drv, gp_val} = {i < 2, i[0]};
			send({8'h0d, rnd[15:2], gp_drv, i[0]});
			chk({gpio_oe, gpio_o}, {gp_drv, gp_val & gp_drv});
			rb(9'h10b, 7'h00);
		end
		for (int i = 0; i < 7; i++) begin
			step();
			rb(codes[i], rnd[6:0]);
		end
		for (int i = 0; i < 4; i++) begin
			step();
			rb({i[1:0] == 2'h0 ? 3'h0 : {1'b0, i[1:0]}, rnd[5:0]}, rnd[12:6]);
		end
		host.frame(23, 24'h0b_ffff, got);
		chk(chan_use_b, {sel1[3:0], sel0[3:0]});
		// A frame outside the special mode must leave the selects alone
		send({2'h1, 6'h0b, 16'hffff});
		chk(chan_use_b, {sel1[3:0], sel0[3:0]});
		// Reset in mid-run clears what earlier commands set
		@(posedge mclk);
		reset_pulse();
		{sel0, sel1} = '0;
		rb(9'h106, 7'h00);
		results();
	end
endmodule

`default_nettype wire

// [sim/dsf_host.sv]
// Serial host model sending frames and collecting the shifted-out word
`timescale 1ns/1ps
`default_nettype none

module dsf_host (
	output var  logic sclk,
	output var  logic sync_n,
	output var  logic sdi,
	input  wire logic sdo
);
	// Clock parked high between frames, it never runs free
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdi = 1'b0;
	end

	// One frame of n bits, MSB first; data moves on the rising edge
	task automatic frame(input int n, input logic [23:0] w, output logic [23:0] r);
		#3; // Keeps the first pin edge of each frame off the sampling clock edge
		r = 24'h00_0000;
		sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = w[23 - i];
			#62.5;
			r[23 - i] = sdo;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
		end
		#62.5;
		sync_n = 1'b1;
		sdi = ~sdi; // Released line never shows a stale level
		#400;
	endtask
endmodule

`default_nettype wire
